/* File: verilog/ioxir_top.sv */
// 24-line quasi-bidirectional expander core: serial slave, port latches,
// change detection and the open-drain interrupt
// assumes scl, sda, the reset pin and the port lines are asynchronous pins;
// open-drain and two-way pins are resolved outside from out and oe
//
// How it works
// - on internal reset release, port latches and serial slave return to defaults.
// - interrupt leaves on an open-drain pin the master can sense.
// - any rising or falling port input edge pulls the interrupt low.
// - interrupt withdraws when port inputs return to their earlier value.
// - a read from or a write to this device withdraws the interrupt.
// - in writes, interrupt released by the port-update strobe at the latest.
// - in reads, interrupt released at the port-sample strobe.
// - port changes during interrupt clearing may go undetected.
// - after clearing completes, every port change raises the interrupt again.
// - while the reset pin is low, latches and slave stay at defaults.
// - after any reset every line is weakly high, usable as input.
// - each written byte reaches its lines only after its acknowledge.

`timescale 1ns/10ps
`default_nettype none

module ioxir_top #(
	parameter logic [ioxir_pkg::ADDR_W-1:0]  SLAVE_ADDR    = ioxir_pkg::ADDR_DEFAULT,
	parameter logic [ioxir_pkg::BLANK_W-1:0] SETTLE_CYCLES = ioxir_pkg::SETTLE_DEFAULT
) (
	// clock and resets
	input  wire logic                         clk_in,
	input  wire logic                         reset_in,
	input  wire logic                         reset_n_in,
	// serial bus
	input  wire logic                         scl_in,
	input  wire logic                         sda_in,
	output logic                              sda_out,
	output logic                              sda_oe_out,
	// interrupt, open drain
	output logic                              int_out,
	output logic                              int_oe_out,
	// port lines
	input  wire logic [ioxir_pkg::PORT_W-1:0] port_a_lines_in,
	output logic      [ioxir_pkg::PORT_W-1:0] port_a_lines_out,
	output logic      [ioxir_pkg::PORT_W-1:0] port_a_lines_oe_out,
	input  wire logic [ioxir_pkg::PORT_W-1:0] port_b_lines_in,
	output logic      [ioxir_pkg::PORT_W-1:0] port_b_lines_out,
	output logic      [ioxir_pkg::PORT_W-1:0] port_b_lines_oe_out,
	input  wire logic [ioxir_pkg::PORT_W-1:0] port_c_lines_in,
	output logic      [ioxir_pkg::PORT_W-1:0] port_c_lines_out,
	output logic      [ioxir_pkg::PORT_W-1:0] port_c_lines_oe_out
);

	import ioxir_pkg::*;

	// byte of the 24-line vector, byte 0 is port a
	function automatic logic [PORT_W-1:0] get_byte(input logic [ALL_W-1:0] vec,
	                                               input logic [IDX_W-1:0] idx);
		get_byte = vec[idx*PORT_W +: PORT_W];
	endfunction

	// byte index wraps after the third byte, so later triplets overwrite
	function automatic logic [IDX_W-1:0] next_idx(input logic [IDX_W-1:0] idx);
		if (idx == LAST_BYTE) begin
			next_idx = FIRST_BYTE;
		end else begin
			next_idx = idx + 2'h1;
		end
	endfunction

	// synchronisers
	logic [ALL_W-1:0]  pins_s1_r;
	logic [ALL_W-1:0]  pins_s2_r;
	logic              scl_s1_r;
	logic              scl_s2_r;
	logic              scl_d_r;
	logic              sda_s1_r;
	logic              sda_s2_r;
	logic              sda_d_r;
	logic              rstn_s1_r;
	logic              rstn_s2_r;

	// slave and port state
	ioxir_state_t      state_r;
	ioxir_state_t      state_nxt;
	logic [CNT_W-1:0]  cnt_r;
	logic [CNT_W-1:0]  cnt_nxt;
	logic [IDX_W-1:0]  idx_r;
	logic [IDX_W-1:0]  idx_nxt;
	logic [PORT_W-1:0] shreg_r;
	logic [PORT_W-1:0] shreg_nxt;
	logic              nack_r;
	logic              nack_nxt;
	logic              sda_oe_r;
	logic              sda_oe_nxt;
	logic [ALL_W-1:0]  latch_r;
	logic [ALL_W-1:0]  latch_nxt;
	logic [ALL_W-1:0]  oe_r;
	logic [ALL_W-1:0]  oe_nxt;
	logic [ALL_W-1:0]  ref_r;
	logic [ALL_W-1:0]  ref_nxt;
	logic [BLANK_W-1:0] blank_r;
	logic [BLANK_W-1:0] blank_nxt;
	logic              int_r;
	logic              int_nxt;
	logic              zero_r;

	// decoded events
	logic              rst;
	logic              scl_rise;
	logic              scl_fall;
	logic              bus_start;
	logic              bus_stop;
	logic              clear;
	logic [PORT_W-1:0] rd_byte;
	logic [PORT_W-1:0] wr_byte;

	// two flops on every pin before any logic looks at it
	always_ff @(posedge clk_in) begin
		pins_s1_r <= {port_c_lines_in, port_b_lines_in, port_a_lines_in};
		pins_s2_r <= pins_s1_r;
		scl_s1_r  <= scl_in;
		scl_s2_r  <= scl_s1_r;
		scl_d_r   <= scl_s2_r;
		sda_s1_r  <= sda_in;
		sda_s2_r  <= sda_s1_r;
		sda_d_r   <= sda_s2_r;
		if (reset_in) begin
			rstn_s1_r <= 1'b0;
			rstn_s2_r <= 1'b0;
		end else begin
			rstn_s1_r <= reset_n_in;
			rstn_s2_r <= rstn_s1_r;
		end
	end

	// the pin reset holds everything until it has been seen high twice
	assign rst       = reset_in | ~rstn_s2_r;
	assign scl_rise  = scl_s2_r & ~scl_d_r;
	assign scl_fall  = ~scl_s2_r & scl_d_r;
	assign bus_start = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
	assign bus_stop  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
	assign rd_byte   = get_byte(pins_s2_r, idx_r);
	assign wr_byte   = shreg_r;

	always_comb begin
		state_nxt  = state_r;
		cnt_nxt    = cnt_r;
		idx_nxt    = idx_r;
		shreg_nxt  = shreg_r;
		nack_nxt   = nack_r;
		sda_oe_nxt = sda_oe_r;
		latch_nxt  = latch_r;
		oe_nxt     = oe_r;
		ref_nxt    = ref_r;
		blank_nxt  = blank_r;
		int_nxt    = int_r;
		clear      = 1'b0;

		if (bus_start) begin
			state_nxt  = ST_ADDR;
			cnt_nxt    = CNT_ZERO;
			idx_nxt    = FIRST_BYTE;
			sda_oe_nxt = 1'b0;
		end else if (bus_stop) begin
			state_nxt  = ST_IDLE;
			sda_oe_nxt = 1'b0;
		end else begin
			// data is taken while scl is high
			if (scl_rise) begin
				unique case (state_r)
					ST_ADDR, ST_WRITE: begin
						shreg_nxt = {shreg_r[PORT_W-2:0], sda_s2_r};
						cnt_nxt   = cnt_r + 4'h1;
					end
					ST_READ: begin
						cnt_nxt = cnt_r + 4'h1;
					end
					ST_ACK_READ: begin
						nack_nxt = sda_s2_r;
					end
					ST_IDLE, ST_ACK_ADDR, ST_ACK_WRITE: begin
					end
				endcase
			end
			// sda only moves while scl is low, so no false start or stop
			if (scl_fall) begin
				unique case (state_r)
					ST_IDLE: begin
					end
					ST_ADDR: begin
						if (cnt_r == BITS_PER_BYTE) begin
							if (shreg_r[PORT_W-1:1] == SLAVE_ADDR) begin
								state_nxt  = ST_ACK_ADDR;
								sda_oe_nxt = 1'b1;
							end else begin
								state_nxt = ST_IDLE;
							end
						end
					end
					ST_ACK_ADDR: begin
						cnt_nxt = CNT_ZERO;
						if (shreg_r[0]) begin
							// port-sample strobe for the first byte
							state_nxt  = ST_READ;
							shreg_nxt  = rd_byte;
							sda_oe_nxt = ~rd_byte[PORT_W-1];
							idx_nxt    = next_idx(idx_r);
							clear      = 1'b1;
						end else begin
							state_nxt  = ST_WRITE;
							sda_oe_nxt = 1'b0;
						end
					end
					ST_WRITE: begin
						if (cnt_r == BITS_PER_BYTE) begin
							state_nxt  = ST_ACK_WRITE;
							sda_oe_nxt = 1'b1;
						end
					end
					ST_ACK_WRITE: begin
						// port-update strobe: byte reaches its lines after its acknowledge
						state_nxt  = ST_WRITE;
						cnt_nxt    = CNT_ZERO;
						sda_oe_nxt = 1'b0;
						latch_nxt[idx_r*PORT_W +: PORT_W] = wr_byte;
						oe_nxt[idx_r*PORT_W +: PORT_W]    = ~wr_byte;
						idx_nxt    = next_idx(idx_r);
						clear      = 1'b1;
					end
					ST_READ: begin
						if (cnt_r == BITS_PER_BYTE) begin
							state_nxt  = ST_ACK_READ;
							sda_oe_nxt = 1'b0;
						end else begin
							shreg_nxt  = {shreg_r[PORT_W-2:0], 1'b0};
							sda_oe_nxt = ~shreg_r[PORT_W-2];
						end
					end
					ST_ACK_READ: begin
						// a nack ends the read; the master then sends stop
						if (nack_r) begin
							state_nxt = ST_IDLE;
						end else begin
							state_nxt  = ST_READ;
							cnt_nxt    = CNT_ZERO;
							shreg_nxt  = rd_byte;
							sda_oe_nxt = ~rd_byte[PORT_W-1];
							idx_nxt    = next_idx(idx_r);
							clear      = 1'b1;
						end
					end
				endcase
			end
		end

		// change detection; the snapshot tracks the lines while a clear settles,
		// trading missed edges in that window for no self-inflicted interrupt
		if (clear) begin
			blank_nxt = SETTLE_CYCLES;
			ref_nxt   = pins_s2_r;
			int_nxt   = 1'b0;
		end else if (blank_r != BLANK_ZERO) begin
			blank_nxt = blank_r - 4'h1;
			ref_nxt   = pins_s2_r;
			int_nxt   = 1'b0;
		end else begin
			int_nxt = (pins_s2_r != ref_r);
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst) begin
			state_r  <= ST_IDLE;
			cnt_r    <= CNT_ZERO;
			idx_r    <= FIRST_BYTE;
			shreg_r  <= BYTE_RST;
			nack_r   <= 1'b0;
			sda_oe_r <= 1'b0;
			latch_r  <= LATCH_RST;
			oe_r     <= OE_RST;
			ref_r    <= LATCH_RST;
			blank_r  <= SETTLE_CYCLES;
			int_r    <= 1'b0;
			zero_r   <= 1'b0;
		end else begin
			state_r  <= state_nxt;
			cnt_r    <= cnt_nxt;
			idx_r    <= idx_nxt;
			shreg_r  <= shreg_nxt;
			nack_r   <= nack_nxt;
			sda_oe_r <= sda_oe_nxt;
			latch_r  <= latch_nxt;
			oe_r     <= oe_nxt;
			ref_r    <= ref_nxt;
			blank_r  <= blank_nxt;
			int_r    <= int_nxt;
			zero_r   <= 1'b0;
		end
	end

	// open drain: the pin is only ever pulled low
	assign sda_out             = zero_r;
	assign sda_oe_out          = sda_oe_r;
	assign int_out             = zero_r;
	assign int_oe_out          = int_r;
	assign port_a_lines_out    = latch_r[0 +: PORT_W];
	assign port_a_lines_oe_out = oe_r[0 +: PORT_W];
	assign port_b_lines_out    = latch_r[PORT_W +: PORT_W];
	assign port_b_lines_oe_out = oe_r[PORT_W +: PORT_W];
	assign port_c_lines_out    = latch_r[2*PORT_W +: PORT_W];
	assign port_c_lines_oe_out = oe_r[2*PORT_W +: PORT_W];

endmodule

`default_nettype wire

/* File: verilog/ioxir_pkg.sv */
// constants and types of the i/o expander change-detect, interrupt and reset block
// assumes one 100 MHz system clock; all widths below are shared by the top module

package ioxir_pkg;

	// port geometry
	localparam int unsigned PORT_W  = 8;
	localparam int unsigned PORT_N  = 3;
	localparam int unsigned ALL_W   = PORT_W * PORT_N;

	// serial side
	localparam int unsigned ADDR_W  = 7;
	localparam int unsigned CNT_W   = 4;
	localparam int unsigned IDX_W   = 2;
	localparam int unsigned BLANK_W = 4;

	localparam logic [CNT_W-1:0]   BITS_PER_BYTE = 4'h8;
	localparam logic [CNT_W-1:0]   CNT_ZERO      = 4'h0;
	localparam logic [IDX_W-1:0]   FIRST_BYTE    = 2'h0;
	localparam logic [IDX_W-1:0]   LAST_BYTE     = 2'h2;
	localparam logic [ADDR_W-1:0]  ADDR_DEFAULT  = 7'h20;

	// reset values: every line released high on its weak pull-up
	localparam logic [ALL_W-1:0]   LATCH_RST     = 24'hFFFFFF;
	localparam logic [ALL_W-1:0]   OE_RST        = 24'h000000;
	localparam logic [PORT_W-1:0]  BYTE_RST      = 8'h00;

	// cycles of blanking after a clear while written lines settle
	localparam logic [BLANK_W-1:0] SETTLE_DEFAULT = 4'h4;
	localparam logic [BLANK_W-1:0] BLANK_ZERO     = 4'h0;

	// serial slave states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK_ADDR,
		ST_WRITE,
		ST_ACK_WRITE,
		ST_READ,
		ST_ACK_READ
	} ioxir_state_t;

endpackage

/* File: tb/ioxir_properties.sv */
// checker: reset defaults, port latches and the change interrupt
// assumes an idle bus rests high and port lines change off the clock edge
`timescale 1ns/10ps
`default_nettype none
module ioxir_properties import ioxir_pkg::*; (
	// clock and resets
	input wire logic		clk_in,
	input wire logic		reset_in,
	input wire logic		reset_n_in,
	// serial bus
	input wire logic		scl_in,
	input wire logic		sda_in,
	input wire logic		sda_out,
	input wire logic		sda_oe_out,
	// interrupt
	input wire logic		int_out,
	input wire logic		int_oe_out,
	// port lines
	input wire logic [PORT_W-1:0]	port_a_lines_in,
	input wire logic [PORT_W-1:0]	port_a_lines_out,
	input wire logic [PORT_W-1:0]	port_a_lines_oe_out,
	input wire logic [PORT_W-1:0]	port_b_lines_in,
	input wire logic [PORT_W-1:0]	port_b_lines_out,
	input wire logic [PORT_W-1:0]	port_b_lines_oe_out,
	input wire logic [PORT_W-1:0]	port_c_lines_in,
	input wire logic [PORT_W-1:0]	port_c_lines_out,
	input wire logic [PORT_W-1:0]	port_c_lines_oe_out
);
	logic [ALL_W-1:0]	ln, ln_d, lo, loe;
	logic [4:0]		hist_r;
	logic [3:0]		idle_r;
	assign ln = {port_c_lines_in, port_b_lines_in, port_a_lines_in};
	assign lo = {port_c_lines_out, port_b_lines_out, port_a_lines_out};
	assign loe = {port_c_lines_oe_out, port_b_lines_oe_out, port_a_lines_oe_out};
	// bus clears blank detection, so edge checks wait for a long idle bus
	always_ff @(posedge clk_in) begin
		ln_d <= ln;
		hist_r <= {hist_r[3:0], ln != ln_d};
		if (reset_in || !reset_n_in || !scl_in || !sda_in)
			idle_r <= 4'h0;
		else if (idle_r != 4'hF)
			idle_r <= idle_r + 4'h1;
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	sequence s_defaults;
		lo == LATCH_RST && loe == OE_RST && !int_oe_out && !sda_oe_out;
	endsequence
	sequence s_quiet_edge;
		idle_r == 4'hF && hist_r[3:0] == 4'h0 && ln != ln_d && !int_oe_out;
	endsequence
	chk_por_defaults: assert property ($fell(reset_in) |-> s_defaults)
		else $error("outputs not at defaults after reset");
	chk_pin_reset: assert property ((!reset_n_in) [*4] |=> s_defaults)
		else $error("outputs left defaults under pin reset");
	chk_open_drain: assert property (!int_out && !sda_out)
		else $error("open-drain output driven high");
	chk_drive_latch: assert property (loe == ~lo)
		else $error("line drive not inverse of latch");
	chk_edge_raises: assert property (s_quiet_edge |-> ##[2:4] int_oe_out)
		else $error("line edge raised no interrupt");
	chk_rise_cause: assert property ($rose(int_oe_out) |-> hist_r != 5'h0)
		else $error("interrupt without line change");
	chk_int_holds: assert property (int_oe_out && idle_r == 4'hF && hist_r == 5'h0 |=> int_oe_out)
		else $error("interrupt dropped with lines unchanged");
	chk_write_release: assert property ($changed(lo) && reset_n_in && !$past(reset_in) |-> !int_oe_out && $past(sda_oe_out, 2))
		else $error("latch update without ack or release");
endmodule
`default_nettype wire

/* File: tb/ioxir_master.sv */
// serial master model: start, stop and nine-bit slots at a 125 ns bit time
// assumes sda is resolved outside with a pull-up; scl rests high between frames
`timescale 1ns/10ps
`default_nettype none
module ioxir_master (
	// serial bus
	input wire logic	sda_in,
	output var logic	scl_out,
	output var logic	sda_low_out
);
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	// non-blocking, so a step that lands on a clock edge is seen after that edge
	task automatic start();
		sda_low_out <= 1'b0;
		#31.25 scl_out <= 1'b1;
		#62.5 sda_low_out <= 1'b1;
		#62.5 scl_out <= 1'b0;
		#31.25;
	endtask
	task automatic stop();
		sda_low_out <= 1'b1;
		#31.25 scl_out <= 1'b1;
		#62.5 sda_low_out <= 1'b0;
		#62.5;
	endtask
	// a one in tx releases the line so the slave may answer
	task automatic bits(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			sda_low_out <= ~tx[i];
			#31.25 scl_out <= 1'b1;
			#31.25 rx[i] = sda_in;
			#31.25 scl_out <= 1'b0;
			#31.25;
		end
	endtask
endmodule
`default_nettype wire

/* File: tb/ioxir_top_tb_top.sv */
// bench top: clock, resets, port-line drivers, master model and scenarios
// assumes checker and master model are compiled before it
`timescale 1ns/10ps
`default_nettype none
module ioxir_top_tb_top;
	import ioxir_pkg::*;
	logic			clk_in, reset_in, reset_n_in, scl, sda_low;
	logic			sda_o, sda_oe, int_o, int_oe, sda;
	logic [PORT_W-1:0]	a_o, a_oe, b_o, b_oe, c_o, c_oe;
	logic [ALL_W-1:0]	ext_r, ln, lo, d;
	logic [8:0]		rx;
	int			fail_count, samples_checked, cyc;
	// a driven low always wins over the outside driver or pull-up
	assign ln = ext_r & ~{c_oe, b_oe, a_oe};
	assign lo = {c_o, b_o, a_o};
	assign sda = ~(sda_low | sda_oe);
	ioxir_master i_master (.sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
	ioxir_top i_dut (.clk_in(clk_in), .reset_in(reset_in), .reset_n_in(reset_n_in),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe),
		.int_out(int_o), .int_oe_out(int_oe),
		.port_a_lines_in(ln[7:0]), .port_a_lines_out(a_o), .port_a_lines_oe_out(a_oe),
		.port_b_lines_in(ln[15:8]), .port_b_lines_out(b_o), .port_b_lines_oe_out(b_oe),
		.port_c_lines_in(ln[23:16]), .port_c_lines_out(c_o), .port_c_lines_oe_out(c_oe));
	task automatic check(input string what, input logic [ALL_W-1:0] exp, got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("%0d checks, %0d mismatches", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic ci(input logic e);
		check("int", ALL_W'(e), ALL_W'(int_oe));
	endtask
	task automatic lines(input logic [ALL_W-1:0] v);
		@(posedge clk_in);
		ext_r <= v;
		repeat (20) @(posedge clk_in);
	endtask
	task automatic wr(input logic [6:0] adr, input logic [47:0] v, input int n);
		i_master.start();
		i_master.bits({adr, 1'b0, 1'b1}, rx);
		check("addr ack", ALL_W'(adr != ADDR_DEFAULT), ALL_W'(rx[0]));
		for (int i = 0; i < n; i++) begin
			i_master.bits({v[8*i +: 8], 1'b1}, rx);
			check("data ack", '0, ALL_W'(rx[0]));
		end
		i_master.stop();
	endtask
	task automatic rd(output logic [ALL_W-1:0] v);
		i_master.start();
		i_master.bits({ADDR_DEFAULT, 1'b1, 1'b1}, rx);
		for (int i = 0; i < 3; i++) begin
			i_master.bits({8'hFF, i == 2}, rx);
			v[8*i +: 8] = rx[8:1];
		end
		i_master.stop();
	endtask
	// six bytes wrap round and overwrite the first three
	function automatic logic [ALL_W-1:0] exp_lo(input logic [47:0] v, input int n);
		return (n > 3) ? v[47:24] : v[23:0];
	endfunction
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fail_count++;
			finish_test();
		end
	end
	initial begin
		logic [47:0] w;
		int k;
		reset_in = 1'b1;
		reset_n_in = 1'b1;
		ext_r = '1;
		cyc = 0;
		fail_count = 0;
		samples_checked = 0;
		k = $urandom(32'hEB1E);
		repeat (6) @(posedge clk_in);
		reset_in <= 1'b0;
		repeat (10) @(posedge clk_in);
		check("latch", LATCH_RST, lo);
		ci(1'b0);
		for (int i = 0; i < 8; i++) begin
			k = $urandom_range(ALL_W - 1);
			lines(~(ALL_W'(1) << k));
			ci(1'b1);
			lines('1);
			ci(1'b0);
		end
		$display("test edges done");
		w[23:0] = 24'($urandom) & 24'hFFFFFE;
		lines(w[23:0]);
		rd(d);
		check("read", w[23:0], d);
		ci(1'b0);
		lines('1);
		ci(1'b1);
		rd(d);
		ci(1'b0);
		$display("test read done");
		w = 48'({$urandom, $urandom});
		lines(24'hFFFFFE);
		wr(ADDR_DEFAULT, w, 6);
		check("latch", exp_lo(w, 6), lo);
		check("drive", ~exp_lo(w, 6), {c_oe, b_oe, a_oe});
		ci(1'b0);
		wr(ADDR_DEFAULT ^ 7'h01, w, 0);
		wr(ADDR_DEFAULT, w, 3);
		check("latch", exp_lo(w, 3), lo);
		$display("test write done");
		@(posedge clk_in);
		reset_n_in <= 1'b0;
		lines(24'h0F0F0F);
		check("latch", LATCH_RST, lo);
		ci(1'b0);
		reset_n_in <= 1'b1;
		// the snapshot follows the lines for a while after release, so wait it out
		repeat (10) @(posedge clk_in);
		lines('1);
		ci(1'b1);
		rd(d);
		check("read", '1, d);
		wr(ADDR_DEFAULT, w, 3);
		@(posedge clk_in);
		reset_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in);
		check("latch", LATCH_RST, lo);
		$display("test resets done");
		finish_test();
	end
endmodule
bind ioxir_top ioxir_properties i_chk (.clk_in(clk_in), .reset_in(reset_in),
	.reset_n_in(reset_n_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe_out(sda_oe_out), .int_out(int_out), .int_oe_out(int_oe_out),
	.port_a_lines_in(port_a_lines_in), .port_a_lines_out(port_a_lines_out),
	.port_a_lines_oe_out(port_a_lines_oe_out), .port_b_lines_in(port_b_lines_in),
	.port_b_lines_out(port_b_lines_out), .port_b_lines_oe_out(port_b_lines_oe_out),
	.port_c_lines_in(port_c_lines_in), .port_c_lines_out(port_c_lines_out),
	.port_c_lines_oe_out(port_c_lines_oe_out));
`default_nettype wire
